//--- logic/algo_debug_params.svh
`ifndef ALGO_DEBUG_PARAMS_SVH
`define ALGO_DEBUG_PARAMS_SVH

// register map: printed offset is not a multiple of four, so it is an index
`define ALGO_DEBUG_CONTROL_IDX 12'h0ee
`define ALGO_DEBUG_CONTROL_ADDR 14'h03b8
`define MEASURE_STATUS_ADDR 14'h03bc
`define MEASURE_STATUS_IDX 12'h0ef
`define ALGO_DEBUG_CONTROL_RST 32'h0000_0000
`define ADDR_W 14

// field positions
`define BYPASS_BIT 26
`define VD_HI 25
`define VD_LO 16
`define VQ_HI 15
`define VQ_LO 6
`define LAUNCH_BIT 5
`define RES_EN_BIT 4
`define IND_EN_BIT 3
`define KE_EN_BIT 2
`define MECH_EN_BIT 1
`define COMMIT_BIT 0

// voltage code boundaries
`define CODE_POS_MAX 10'h1f4
`define CODE_NEG_BASE 10'h200
`define CODE_NEG_MAX 10'h3e8

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/algo_debug_pkg.sv
package algo_debug_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RES, ST_IND, ST_KE, ST_MECH
  } measure_e;
endpackage

//--- logic/foc_debug_override_control.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "algo_debug_params.svh"

// Overview of operation
// RULE_01: 32-bit write-only debug control register at EEh, resets to zero.
// RULE_02: bypass bit 26 disables current and speed loops, forces voltages.
// RULE_03: direct voltage from bits 25-16: <500 positive, >512 negative; the code also takes code 500 as a valid positive value.
// RULE_04: quadrature voltage from bits 15-6, same coding; valid 0-500,512-1000.
// RULE_05: writing 1 to bit 5 starts the parameter measurement routine.
// RULE_06: resistance measured only when bit 4 is set.
// RULE_07: inductance measured only when bit 3 is set.
// RULE_08: back-EMF constant measured only when bit 2 is set.
// RULE_09: mechanical parameters measured only when bit 1 is set.
// RULE_10: writing 1 to bit 0 copies measured results into shadow storage.
// RULE_11: software picks enables before launch, commits after completion.
module foc_debug_override_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic regulator_bypass,
  output logic [9:0] direct_voltage_code,
  output logic direct_voltage_negative,
  output logic direct_voltage_valid,
  output logic [9:0] quadrature_voltage_code,
  output logic quadrature_voltage_negative,
  output logic quadrature_voltage_valid,
  output logic measure_start,
  output logic measure_resistance,
  output logic measure_inductance,
  output logic measure_back_emf,
  output logic measure_mechanical,
  input wire logic measure_step_done,
  output logic measure_busy,
  output logic shadow_commit
);


  // control register image; launch and commit bits self-clear
  // only the configuration fields are kept: the two command bits
  // would otherwise re-fire on the next write that leaves them set
  logic [31:0] ctrl_r;
  logic [13:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic start_r;
  logic commit_r;
  logic results_ready_r;

  // sequencer state; one step of the routine is active at a time
  algo_debug_pkg::measure_e state_r;
  algo_debug_pkg::measure_e state_nxt;

  // write channel capture, either order
  // each channel is latched on its own handshake, so the master
  // may offer address and data in any order or together;
  // nothing new is taken while a response is still pending
  wire aw_take = s_axi_awvalid && !aw_have_r && !bvalid_r;
  wire w_take = s_axi_wvalid && !w_have_r && !bvalid_r;
  wire wr_go = aw_have_r && w_have_r && !bvalid_r;
  wire wr_hit = awaddr_r[13:2] == `ALGO_DEBUG_CONTROL_IDX; // RULE_01
  wire wr_ctrl = wr_go && wr_hit;
  wire wr_status = awaddr_r[13:2] == `MEASURE_STATUS_IDX;

  // ready lines are combinational: a channel is taken in the
  // same cycle it is offered, costing no wait state
  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;


  // byte-lane merge of the new control word
  // lanes that are not strobed keep their old value, so a narrow
  // write can change the direct voltage field without touching enables
  wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                           {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] ctrl_merge = (ctrl_r & ~strb_mask) | (wdata_r & strb_mask);


  // launch only from idle; a launch mid-routine is dropped
  // both command bits need their own lane strobed, so a partial
  // write aimed at the upper fields never starts or commits
  wire launch_hit = wr_ctrl && ctrl_merge[`LAUNCH_BIT] &&
                    strb_mask[`LAUNCH_BIT]; // RULE_05
  wire commit_hit = wr_ctrl && ctrl_merge[`COMMIT_BIT] &&
                    strb_mask[`COMMIT_BIT]; // RULE_10


  // address and data holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end


  // write response; unmapped writes get slverr
  // the status word is read-only: a write there is answered okay
  // and ignored, so software probing the map does not see errors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_hit || wr_status) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end


  // control register; command bits do not stay set
  // updated on the same edge that raises the write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `ALGO_DEBUG_CONTROL_RST; // RULE_01
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_merge & ~((32'h1 << `LAUNCH_BIT) |
                               (32'h1 << `COMMIT_BIT));
    end
  end


  // read side: control register is write-only, reads back zero
  // the status word is the only way software can see that the
  // routine has finished before it asks for a commit
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire rd_ctrl = s_axi_araddr[13:2] == `ALGO_DEBUG_CONTROL_IDX;
  wire rd_status = s_axi_araddr[13:2] == `MEASURE_STATUS_IDX;
  wire [31:0] status_word = {29'h0, results_ready_r, measure_busy,
                             regulator_bypass};

  // read data outputs come straight from their registers; arready is combinational
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;


  // read response; one read in flight at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_status ? status_word : 32'h0; // RULE_01
      rresp_r <= (rd_ctrl || rd_status) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end


  // voltage override outputs straight from the register
  // the loops downstream only honour the forced references while
  // this bit is high; clearing it hands control back at once
  assign regulator_bypass = ctrl_r[`BYPASS_BIT]; // RULE_02
  wire [9:0] vd_raw = ctrl_r[`VD_HI:`VD_LO];
  wire [9:0] vq_raw = ctrl_r[`VQ_HI:`VQ_LO];

  // both axes share one coding, so one decoder serves each
  // magnitude is code or code-512, divided by 500 downstream
  voltage_code_decode #(.W(10)) i_vd_decode ( // RULE_03
    .bypass(regulator_bypass),
    .raw(vd_raw),
    .magnitude(direct_voltage_code),
    .negative(direct_voltage_negative),
    .valid(direct_voltage_valid)
  );

  // quadrature axis, same coding and the same valid ranges
  voltage_code_decode #(.W(10)) i_vq_decode ( // RULE_04
    .bypass(regulator_bypass),
    .raw(vq_raw),
    .magnitude(quadrature_voltage_code),
    .negative(quadrature_voltage_negative),
    .valid(quadrature_voltage_valid)
  );

  // enables read from the register decide which steps run
  // they are read live from the register, so software must not
  // change them while the routine is busy
  wire en_res = ctrl_r[`RES_EN_BIT];
  wire en_ind = ctrl_r[`IND_EN_BIT];
  wire en_ke = ctrl_r[`KE_EN_BIT];
  wire en_mech = ctrl_r[`MECH_EN_BIT];


  // step sequencer: skips disabled measurements
  // order is fixed: resistance, inductance, back-emf, mechanical;
  // each step ends on a done pulse from the measuring engine
  // a launch with no enables pulses start but never leaves idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      algo_debug_pkg::ST_IDLE: begin
        if (start_r) begin
          if (en_res) state_nxt = algo_debug_pkg::ST_RES; // RULE_06
          else if (en_ind) state_nxt = algo_debug_pkg::ST_IND; // RULE_07
          else if (en_ke) state_nxt = algo_debug_pkg::ST_KE; // RULE_08
          else if (en_mech) state_nxt = algo_debug_pkg::ST_MECH; // RULE_09
        end
      end
      algo_debug_pkg::ST_RES: begin
        if (measure_step_done) begin
          if (en_ind) state_nxt = algo_debug_pkg::ST_IND; // RULE_07
          else if (en_ke) state_nxt = algo_debug_pkg::ST_KE;
          else if (en_mech) state_nxt = algo_debug_pkg::ST_MECH;
          else state_nxt = algo_debug_pkg::ST_IDLE;
        end
      end
      algo_debug_pkg::ST_IND: begin
        if (measure_step_done) begin
          if (en_ke) state_nxt = algo_debug_pkg::ST_KE; // RULE_08
          else if (en_mech) state_nxt = algo_debug_pkg::ST_MECH;
          else state_nxt = algo_debug_pkg::ST_IDLE;
        end
      end
      algo_debug_pkg::ST_KE: begin
        if (measure_step_done) begin
          if (en_mech) state_nxt = algo_debug_pkg::ST_MECH; // RULE_09
          else state_nxt = algo_debug_pkg::ST_IDLE;
        end
      end
      algo_debug_pkg::ST_MECH: begin
        if (measure_step_done) state_nxt = algo_debug_pkg::ST_IDLE;
      end
      default: state_nxt = algo_debug_pkg::ST_IDLE;
    endcase
  end


  // launch strobe held one cycle so the new enables are in ctrl_r
  // results_ready clears on a fresh start and sets as the last
  // step finishes; the two events never meet in one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= algo_debug_pkg::ST_IDLE;
      start_r <= 1'b0;
      commit_r <= 1'b0;
      results_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_r <= launch_hit && !measure_busy; // RULE_05
      commit_r <= commit_hit; // RULE_10
      if (start_r && !measure_busy) results_ready_r <= 1'b0;
      else if (measure_busy && state_nxt == algo_debug_pkg::ST_IDLE)
        results_ready_r <= 1'b1;
    end
  end


  // step outputs decode the state register directly
  assign measure_busy = state_r != algo_debug_pkg::ST_IDLE;
  assign measure_start = start_r;
  assign measure_resistance = state_r == algo_debug_pkg::ST_RES; // RULE_06
  assign measure_inductance = state_r == algo_debug_pkg::ST_IND; // RULE_07
  assign measure_back_emf = state_r == algo_debug_pkg::ST_KE; // RULE_08
  assign measure_mechanical = state_r == algo_debug_pkg::ST_MECH; // RULE_09
  // commit is not gated by the routine; software owns the timing
  assign shadow_commit = commit_r; // RULE_10

endmodule

// one axis of the forced voltage decode
// width stays at the field's documented ten bits
module voltage_code_decode #(
  parameter int W = 10
) (
  input wire logic bypass,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] magnitude,
  output logic negative,
  output logic valid
);

  // code 512 itself means zero, so the offset applies from 512 up
  wire upper_half = raw >= `CODE_NEG_BASE; // RULE_03
  wire in_pos_range = raw <= `CODE_POS_MAX; // RULE_04
  wire in_neg_range = upper_half && (raw <= `CODE_NEG_MAX); // RULE_04

  // sign only strictly above 512, so 512 reads as plus zero
  assign negative = raw > `CODE_NEG_BASE; // RULE_03

  // kept as an integer code; the divide by 500 happens downstream
  assign magnitude = upper_half ? raw - `CODE_NEG_BASE : raw; // RULE_03

  // invalid codes still pass through but are flagged, so the loop
  // can hold its last good reference instead of a wild value
  assign valid = bypass && (in_pos_range || in_neg_range); // RULE_04

endmodule

//--- sim/foc_debug_override_control_properties.sv
`timescale 1ns/1ps
module foc_debug_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic regulator_bypass,
  input wire logic direct_voltage_valid,
  input wire logic quadrature_voltage_valid,
  input wire logic measure_start,
  input wire logic measure_resistance,
  input wire logic measure_inductance,
  input wire logic measure_back_emf,
  input wire logic measure_mechanical,
  input wire logic measure_step_done,
  input wire logic measure_busy,
  input wire logic shadow_commit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // last step done must leave the routine idle
  sequence mech_end;
    measure_mechanical && measure_step_done;
  endsequence
  a_vd_gated: assert property (
    direct_voltage_valid |-> regulator_bypass)
    else $error("vd valid without bypass");
  a_vq_gated: assert property (
    quadrature_voltage_valid |-> regulator_bypass)
    else $error("vq valid without bypass");
  a_start_pulse: assert property (measure_start |=> !measure_start)
    else $error("start longer than one cycle");
  a_res_hold: assert property (
    measure_resistance && !measure_step_done
    |=> measure_resistance && measure_busy)
    else $error("resistance step dropped early");
  a_ind_order: assert property (
    measure_inductance && measure_step_done
    |=> !measure_resistance)
    else $error("step order broken after inductance");
  a_ke_order: assert property (
    measure_back_emf && measure_step_done
    |=> !measure_resistance && !measure_inductance)
    else $error("step order broken after back emf");
  a_mech_last: assert property (mech_end |=> !measure_busy)
    else $error("busy after last step");
  a_commit_pulse: assert property (shadow_commit |=> !shadow_commit)
    else $error("commit longer than one cycle");
endmodule
bind foc_debug_override_control foc_debug_checker i_chk (.*);

//--- sim/foc_debug_override_control_test.sv
`timescale 1ns/1ps
`include "algo_debug_params.svh"
module foc_debug_override_control_test;
  logic aclk = 0, aresetn = 0, measure_step_done = 0;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, regulator_bypass, measure_start, shadow_commit;
  logic direct_voltage_negative, direct_voltage_valid;
  logic quadrature_voltage_negative, quadrature_voltage_valid;
  logic measure_resistance, measure_inductance, measure_busy;
  logic measure_back_emf, measure_mechanical;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [9:0] direct_voltage_code, quadrature_voltage_code;
  logic [15:0] lf = 16'd52137;
  int fails = 0, tests_run = 0, starts = 0, commits = 0;
  foc_debug_override_control i_dut (.*);
  always #2 aclk = ~aclk;
  // pulses are counted so a one-cycle output is never missed
  always @(posedge aclk) begin
    starts <= starts + (measure_start === 1'b1);
    commits <= commits + (shadow_commit === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tmo(input logic ok);
    if (ok !== 1'b1) begin
      fails++;
      results();
    end
  endtask
  // ready sampled at the rising edge, released right after it
  task wr(input logic [13:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    ha = 0;
    hw = 0;
    hb = 0;
    for (int n = 0; n < 100 && !hb; n++) begin
      @(posedge aclk);
      if (!ha && s_axi_awready) begin
        ha = 1;
        s_axi_awvalid <= 0;
      end
      if (!hw && s_axi_wready) begin
        hw = 1;
        s_axi_wvalid <= 0;
      end
      if (s_axi_bvalid) begin
        hb = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    tmo(hb);
  endtask
  task rdr(input logic [13:0] a);
    logic ha, hb;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    ha = 0;
    hb = 0;
    for (int n = 0; n < 100 && !hb; n++) begin
      @(posedge aclk);
      if (!ha && s_axi_arready) begin
        ha = 1;
        s_axi_arvalid <= 0;
      end
      if (s_axi_rvalid) begin
        hb = 1;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    tmo(hb);
  endtask
  function logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // valid, negative, magnitude (magnitude only meaningful when valid)
  function logic [11:0] vexp(input logic b, input logic [9:0] c);
    logic v;
    v = b && (c <= 10'h1f4 || (c >= 10'h200 && c <= 10'h3e8));
    return {v, c > 10'h200, v ? (c >= 10'h200 ? c - 10'h200 : c) : 10'h0};
  endfunction
  initial begin
    logic [9:0] cn [8] = '{10'h000, 10'h1f4, 10'h1f5, 10'h1ff,
                           10'h200, 10'h201, 10'h3e8, 10'h3e9};
    logic [9:0] cd, cq;
    logic b;
    logic [3:0] st;
    int k;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rdr(`ALGO_DEBUG_CONTROL_ADDR);
    chk(rd, `ALGO_DEBUG_CONTROL_RST);
    wr(14'h0400, 32'h0400_0000);
    chk({resp, regulator_bypass}, {`RESP_SLVERR, 1'b0});
    // corner codes first, then random fields and bypass
    for (int i = 0; i < 40; i++) begin
      lf = nx(lf);
      cd = i < 8 ? cn[i] : lf[9:0];
      cq = i < 8 ? cn[7 - i] : lf[15:6];
      b = lf[5] | (i < 8);
      wr(`ALGO_DEBUG_CONTROL_ADDR, {5'h0, b, cd, cq, 6'h0});
      chk({regulator_bypass, direct_voltage_valid, direct_voltage_negative,
        direct_voltage_valid ? direct_voltage_code : 10'h0},
        {b, vexp(b, cd)});
      chk({quadrature_voltage_valid, quadrature_voltage_negative,
        quadrature_voltage_valid ? quadrature_voltage_code : 10'h0},
        vexp(b, cq));
    end
    // every enable pattern, steps must come in order and skip disabled
    for (int p = 0; p < 16; p++) begin
      k = starts;
      wr(`ALGO_DEBUG_CONTROL_ADDR, {26'h0, 1'b1, p[3:0], 1'b0});
      for (int s = 3; s >= 0; s--) if (p[s]) begin
        st = 0;
        for (int n = 0; n < 100 && st == 0; n++) begin
          @(negedge aclk);
          st = {measure_resistance, measure_inductance,
            measure_back_emf, measure_mechanical};
        end
        tmo(st != 0);
        chk(st, 4'h1 << s);
        // a second launch while busy must be ignored
        if (p == 15 && s == 3)
          wr(`ALGO_DEBUG_CONTROL_ADDR, {26'h0, 1'b1, p[3:0], 1'b0});
        @(posedge aclk);
        measure_step_done <= 1;
        @(posedge aclk);
        measure_step_done <= 0;
      end
      repeat (2) @(negedge aclk);
      chk(starts, k + 1);
      chk(measure_busy, 1'b0);
    end
    rdr(`MEASURE_STATUS_ADDR);
    chk({resp, rd}, {`RESP_OKAY, 32'h0000_0004});
    k = commits;
    wr(`ALGO_DEBUG_CONTROL_ADDR, 32'h0000_0001);
    repeat (2) @(negedge aclk);
    chk(commits, k + 1);
    rdr(`ALGO_DEBUG_CONTROL_ADDR);
    chk(rd, 32'h0000_0000);
    results();
  end
endmodule
